// >>> dv/gcf_agc_reader.sv
/* Model of the external gain logic that integrates the two flag pins.
   Assumes the pins are sampled on the block clock. */
`timescale 1ns/1ps
module gcf_agc_reader (
	input wire logic clk, // Block clock
	input wire logic reset, // Reset, active high
	input wire logic countClear, // Restart both counts
	input wire logic firstFlagPin, // First pin
	input wire logic secondFlagPin, // Second pin
	output int firstHigh, // High cycles, first pin
	output int secondHigh // High cycles, second pin
);
	// Count the cycles each pin stays high
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			firstHigh <= 0;
			secondHigh <= 0;
		end else if (countClear) begin
			firstHigh <= 0;
			secondHigh <= 0;
		end else begin
			firstHigh <= firstHigh + int'(firstFlagPin);
			secondHigh <= secondHigh + int'(secondFlagPin);
		end
	end
endmodule

// >>> dv/gcf_flag_out_props.sv
/* Checker for the flag output block: mirrors register writes, checks outputs.
   Assumes it is bound to gcf_flag_out and sees only its ports. */
`timescale 1ns/1ps
module gcf_flag_out_props #(
	parameter int PEAK_W = 12 // Peak width
) (
	input wire logic clk, // Clock
	input wire logic reset, // Reset
	input wire logic [9:0] regAddr, // Index
	input wire logic [7:0] regWrData, // Write data
	input wire logic regWr, // Write strobe
	input wire logic regRd, // Read strobe
	input wire logic [7:0] regRdData, // Read data
	input wire logic peakValid, // Peak strobe
	input wire logic [PEAK_W-1:0] peakMag, // Peak value
	input wire logic convValid, // Converter strobe
	input wire logic convFullScale, // Full scale
	input wire logic firstFlagPin, // First pin
	input wire logic secondFlagPin, // Second pin
	input wire logic irq // Interrupt
);
	logic [11:0] thr0; // Threshold zero copy
	logic [2:0] src0; // First source copy
	logic [7:0] en; // Enables copy
	logic [3:0] mask; // Mask copy
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	// Mirror writes seen on the port
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			thr0 <= '0;
			src0 <= '0;
			en <= '0;
			mask <= '0;
		end else if (regWr) begin
			case (regAddr)
				gcf_pkg::OFS_PEAK0_LO: thr0[7:0] <= regWrData;
				gcf_pkg::OFS_PEAK0_HI: thr0[11:8] <= regWrData[3:0];
				gcf_pkg::OFS_SRC0: src0 <= regWrData[2:0];
				gcf_pkg::OFS_FLAG_EN: en <= regWrData;
				gcf_pkg::OFS_IRQ_MASK: mask <= regWrData[3:0];
				default: ;
			endcase
		end
	end
	chk_read_idle: assert property (!regRd |=> regRdData == 8'h00)
		else $error("read data not zero outside a read");
	chk_read_source: assert property (
		regRd && regAddr == gcf_pkg::OFS_SRC0 |=> regRdData == {5'h00, src0})
		else $error("first source readback wrong");
	chk_read_enables: assert property (
		regRd && regAddr == gcf_pkg::OFS_FLAG_EN |=> regRdData == (en & 8'h13))
		else $error("enable readback wrong");
	chk_first_off: assert property ((!en[0])[*3] |-> !firstFlagPin)
		else $error("first pin high while off");
	chk_second_off: assert property ((!en[1])[*3] |-> !secondFlagPin)
		else $error("second pin high while off");
	chk_unlisted_low: assert property (
		(!(src0 inside {3'b000, 3'b100, 3'b101, 3'b110}))[*3] |-> !firstFlagPin)
		else $error("unlisted code drives pin");
	chk_above_high: assert property (
		peakValid && peakMag > thr0 ##1 src0 == 3'b100 && en[0] |=> firstFlagPin)
		else $error("peak above threshold not flagged");
	chk_above_low: assert property (
		peakValid && peakMag <= thr0 ##1 src0 == 3'b100 && en[0] && !en[4]
		|=> !firstFlagPin)
		else $error("peak at or below threshold flagged");
	chk_irq_masked: assert property ((mask == 4'h0)[*2] |-> !irq)
		else $error("interrupt while all masked");
endmodule

// >>> dv/tb_gcf_flag_out.sv
/* Bench for gcf_flag_out: registers, peak flags, floor hold, reset pulse, irq.
   Assumes gcf_pkg, the checker and the pin reader are compiled first. */
`timescale 1ns/1ps
module tb_gcf_flag_out;
	logic clk, reset, regWr, regRd, peakValid, convValid, convFullScale; // Drives
	logic [9:0] regAddr; // Index
	logic [7:0] regWrData, regRdData; // Data
	logic [11:0] peakMag; // Peak value
	logic firstFlagPin, secondFlagPin, irq, clrCount; // Pins and model clear
	int firstHigh, secondHigh; // Model counts
	int n_errors = 0; // Mismatches
	int checks = 0; // Comparisons
	logic [7:0] odd [4] = '{8'h01, 8'h02, 8'h03, 8'h07}; // Unlisted codes
	gcf_flag_out i_dut (.clk(clk), .reset(reset), .regAddr(regAddr), .regWrData(regWrData),
		.regWr(regWr), .regRd(regRd), .regRdData(regRdData), .peakValid(peakValid),
		.peakMag(peakMag), .convValid(convValid), .convFullScale(convFullScale),
		.firstFlagPin(firstFlagPin), .secondFlagPin(secondFlagPin), .irq(irq));
	gcf_agc_reader i_reader (.clk(clk), .reset(reset), .countClear(clrCount),
		.firstFlagPin(firstFlagPin), .secondFlagPin(secondFlagPin),
		.firstHigh(firstHigh), .secondHigh(secondHigh));
	// 4 ns clock
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task automatic compare(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		@(posedge clk);
		regWr <= 1'b1;
		regAddr <= a;
		regWrData <= d;
		@(posedge clk);
		regWr <= 1'b0;
	endtask
	task automatic rd(input logic [9:0] a, input logic [7:0] exp);
		@(posedge clk);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge clk);
		regRd <= 1'b0;
		#1 compare(regRdData, exp);
	endtask
	task automatic peak(input logic [11:0] m);
		@(posedge clk);
		peakValid <= 1'b1;
		peakMag <= m;
		@(posedge clk);
		peakValid <= 1'b0;
	endtask
	// Pins settle two edges after their cause
	task automatic pins(input logic p0, input logic p1);
		repeat (2) @(posedge clk);
		#1 compare({6'h00, firstFlagPin, secondFlagPin}, {6'h00, p0, p1});
	endtask
	task automatic irqIs(input logic e);
		repeat (2) @(posedge clk);
		#1 compare({7'h00, irq}, {7'h00, e});
	endtask
	function automatic logic [9:0] adr(input int i);
		return (i == 10) ? gcf_pkg::OFS_FLAG_EN : gcf_pkg::OFS_PEAK0_LO + 10'(i);
	endfunction
	// Writable bits of each register
	function automatic logic [7:0] wmask(input int i);
		case (i)
			0, 2, 4, 6: return 8'hff;
			8, 9: return 8'h07;
			10: return 8'h13;
			default: return 8'h0f;
		endcase
	endfunction
	task automatic report_and_stop;
		$display("checks %0d, n_errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// Watchdog
	initial begin
		#40000;
		n_errors++;
		report_and_stop();
	end
	initial begin
		{reset, regWr, regRd, peakValid, convValid, convFullScale, clrCount} = 7'h41;
		regAddr = '0;
		regWrData = '0;
		peakMag = '0;
		reset = 1'b1;
		repeat (5) @(posedge clk);
		reset <= 1'b0;
		for (int i = 0; i < 11; i++) begin
			rd(adr(i), 8'h00);
			wr(adr(i), 8'hff);
			rd(adr(i), wmask(i));
			wr(adr(i), 8'h00);
		end
		rd(gcf_pkg::OFS_RST_LIMIT, 8'h05);
		rd(gcf_pkg::OFS_RST_LEN, 8'h01);
		rd(10'h1ff, 8'h00);
		$display("test registers done");
		wr(gcf_pkg::OFS_PEAK0_HI, 8'h01);
		wr(gcf_pkg::OFS_PEAK1_HI, 8'h08);
		wr(gcf_pkg::OFS_SRC0, 8'h04);
		wr(gcf_pkg::OFS_SRC1, 8'h05);
		wr(gcf_pkg::OFS_FLAG_EN, 8'h03);
		peak(12'h200);
		pins(1'b1, 1'b0);
		peak(12'h800);
		pins(1'b1, 1'b0);
		peak(12'h801);
		pins(1'b1, 1'b1);
		peak(12'h100);
		pins(1'b0, 1'b0);
		peak(12'h900);
		foreach (odd[k]) begin
			wr(gcf_pkg::OFS_SRC0, odd[k]);
			pins(1'b0, 1'b1);
		end
		wr(gcf_pkg::OFS_FLAG_EN, 8'h00);
		pins(1'b0, 1'b0);
		$display("test peaks done");
		wr(gcf_pkg::OFS_FLOOR_LO, 8'h10);
		wr(gcf_pkg::OFS_HOLD_MANT, 8'h03);
		wr(gcf_pkg::OFS_HOLD_EXP, 8'h01);
		wr(gcf_pkg::OFS_SRC0, 8'h06);
		wr(gcf_pkg::OFS_FLAG_EN, 8'h01);
		peak(12'h010);
		repeat (5) peak(12'h00f);
		pins(1'b0, 1'b0);
		peak(12'h00f);
		pins(1'b1, 1'b0);
		peak(12'h010);
		pins(1'b0, 1'b0);
		$display("test floor done");
		wr(gcf_pkg::OFS_IRQ_STATUS, 8'h0f);
		wr(gcf_pkg::OFS_IRQ_MASK, 8'h01);
		wr(gcf_pkg::OFS_SRC0, 8'h00);
		wr(gcf_pkg::OFS_SRC1, 8'h04);
		wr(gcf_pkg::OFS_FLAG_EN, 8'h13);
		irqIs(1'b0);
		clrCount <= 1'b1;
		@(posedge clk);
		clrCount <= 1'b0;
		convValid <= 1'b1;
		convFullScale <= 1'b1;
		repeat (7) @(posedge clk);
		convFullScale <= 1'b0;
		repeat (40) @(posedge clk);
		compare(8'(firstHigh), 8'd16);
		compare(8'(secondHigh), 8'd16);
		rd(gcf_pkg::OFS_IRQ_STATUS, 8'h01);
		irqIs(1'b1);
		wr(gcf_pkg::OFS_IRQ_MASK, 8'h00);
		irqIs(1'b0);
		wr(gcf_pkg::OFS_IRQ_MASK, 8'h01);
		irqIs(1'b1);
		wr(gcf_pkg::OFS_IRQ_STATUS, 8'h01);
		irqIs(1'b0);
		$display("test pulse done");
		report_and_stop();
	end
endmodule
bind gcf_flag_out gcf_flag_out_props #(.PEAK_W(PEAK_W)) i_props (.clk(clk), .reset(reset),
	.regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
	.regRdData(regRdData), .peakValid(peakValid), .peakMag(peakMag), .convValid(convValid),
	.convFullScale(convFullScale), .firstFlagPin(firstFlagPin),
	.secondFlagPin(secondFlagPin), .irq(irq));

// >>> rtl/gcf_flag_out.sv
/*
 * Peak-detect and flag-output logic for automatic gain control: threshold
 * compares, floor hold timer, converter reset detector and pulse, register
 * file, event interrupt and the two flag pins.
 * Assumes peak and converter sample strobes are on clk; flag pins are pure
 * outputs read by external gain control logic.
 */
// Chosen here: the plain strobed port.
`timescale 1ns/1ps

module gcf_flag_out #(
	parameter int PEAK_W = 12 // Peak magnitude width
) (
	input wire logic clk, // 250 MHz clock
	input wire logic reset, // Asynchronous reset, active high
	input wire logic [9:0] regAddr, // Register index
	input wire logic [7:0] regWrData, // Register write data
	input wire logic regWr, // Write strobe
	input wire logic regRd, // Read strobe
	output logic [7:0] regRdData, // Read data, cycle after the strobe
	input wire logic peakValid, // New filtered-output peak sample
	input wire logic [PEAK_W-1:0] peakMag, // Filtered-output peak magnitude
	input wire logic convValid, // New converter sample
	input wire logic convFullScale, // Converter sample is at full scale
	output logic firstFlagPin, // First flag pin
	output logic secondFlagPin, // Second flag pin
	output logic irq // Level interrupt
);
	initial begin
		if (PEAK_W != 12) begin
			$error("gcf_flag_out: peak width must be 12");
		end
	end

	// Configuration registers
	logic [7:0] peak0Lo; // Threshold zero low bits
	logic [3:0] peak0Hi; // Threshold zero high bits
	logic [7:0] peak1Lo; // Threshold one low bits
	logic [3:0] peak1Hi; // Threshold one high bits
	logic [7:0] floorLo; // Floor low bits
	logic [3:0] floorHi; // Floor high bits
	logic [7:0] holdMant; // Hold interval mantissa
	logic [3:0] holdExp; // Hold interval exponent
	logic [2:0] firstFlagSource; // First flag source code
	logic [2:0] secondFlagSource; // Second flag source code
	logic firstFlagOutputOn; // First flag enable
	logic secondFlagOutputOn; // Second flag enable
	logic combineReset; // OR reset pulse into peak flags
	logic [2:0] resetCountLimit; // Full-scale count limit
	logic [4:0] resetPulseLength; // Pulse length field
	gcf_pkg::gcf_ind_s irqStatus; // Sticky events
	gcf_pkg::gcf_ind_s irqMask; // Interrupt mask

	// Indicator state
	gcf_pkg::gcf_ind_s ind; // Live indicators
	gcf_pkg::gcf_ind_s indPrev; // Indicators one cycle ago
	logic [23:0] holdCount; // Samples spent below the floor
	logic [7:0] fsWindow; // Full-scale history of eight samples
	logic [7:0] pulseCount; // Converter clocks left in the pulse

	// Full 12-bit thresholds and the 24-bit hold interval
	logic [11:0] thr0; // Threshold zero
	logic [11:0] thr1; // Threshold one
	logic [11:0] thrFloor; // Floor threshold
	logic [23:0] holdTarget; // Hold interval in samples
	assign thr0 = {peak0Hi, peak0Lo};
	assign thr1 = {peak1Hi, peak1Lo};
	assign thrFloor = {floorHi, floorLo};
	assign holdTarget = 24'({holdMant, 15'h0000} >> (5'd15 - 5'(holdExp)));

	// Count of set bits in an eight-sample window
	function automatic logic [3:0] onesCount(input logic [7:0] w);
		logic [3:0] n;
		n = 4'h0;
		for (int i = 0; i < 8; i++) begin
			n = n + {3'h0, w[i]};
		end
		return n;
	endfunction

	// Choose an indicator by source code, with the combine option
	function automatic logic pickFlag(input logic [2:0] code, input gcf_pkg::gcf_ind_s v,
			input logic comb);
		logic r;
		case (code)
			gcf_pkg::SRC_RESET: r = v.resetPulse;
			gcf_pkg::SRC_ABOVE0: r = v.above0 | (comb & v.resetPulse);
			gcf_pkg::SRC_ABOVE1: r = v.above1 | (comb & v.resetPulse);
			gcf_pkg::SRC_BELOW: r = v.below | (comb & v.resetPulse);
			default: r = 1'b0;
		endcase
		return r;
	endfunction

	// Register writes; shorter fields keep the low bits
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			peak0Lo <= gcf_pkg::RST_ZERO;
			peak0Hi <= gcf_pkg::RST_ZERO[3:0];
			peak1Lo <= gcf_pkg::RST_ZERO;
			peak1Hi <= gcf_pkg::RST_ZERO[3:0];
			floorLo <= gcf_pkg::RST_ZERO;
			floorHi <= gcf_pkg::RST_ZERO[3:0];
			holdMant <= gcf_pkg::RST_ZERO;
			holdExp <= gcf_pkg::RST_ZERO[3:0];
			firstFlagSource <= gcf_pkg::RST_ZERO[2:0];
			secondFlagSource <= gcf_pkg::RST_ZERO[2:0];
			firstFlagOutputOn <= 1'b0;
			secondFlagOutputOn <= 1'b0;
			combineReset <= 1'b0;
			resetCountLimit <= gcf_pkg::RST_LIMIT;
			resetPulseLength <= gcf_pkg::RST_LEN;
			irqMask <= '0;
		end else if (regWr) begin
			case (regAddr)
				gcf_pkg::OFS_PEAK0_LO: peak0Lo <= regWrData;
				gcf_pkg::OFS_PEAK0_HI: peak0Hi <= regWrData[3:0];
				gcf_pkg::OFS_PEAK1_LO: peak1Lo <= regWrData;
				gcf_pkg::OFS_PEAK1_HI: peak1Hi <= regWrData[3:0];
				gcf_pkg::OFS_FLOOR_LO: floorLo <= regWrData;
				gcf_pkg::OFS_FLOOR_HI: floorHi <= regWrData[3:0];
				gcf_pkg::OFS_HOLD_MANT: holdMant <= regWrData;
				gcf_pkg::OFS_HOLD_EXP: holdExp <= regWrData[3:0];
				gcf_pkg::OFS_SRC0: firstFlagSource <= regWrData[2:0];
				gcf_pkg::OFS_SRC1: secondFlagSource <= regWrData[2:0];
				gcf_pkg::OFS_FLAG_EN: begin
					firstFlagOutputOn <= regWrData[gcf_pkg::BIT_FLAG0_ON];
					secondFlagOutputOn <= regWrData[gcf_pkg::BIT_FLAG1_ON];
					combineReset <= regWrData[gcf_pkg::BIT_COMBINE];
				end
				gcf_pkg::OFS_RST_LIMIT: resetCountLimit <= regWrData[2:0];
				gcf_pkg::OFS_RST_LEN: resetPulseLength <= regWrData[4:0];
				gcf_pkg::OFS_IRQ_MASK: irqMask <= regWrData[3:0];
				default: begin
					// Unmapped or read-only: ignored
				end
			endcase
		end
	end

	// Read data, valid only in the cycle after the read strobe
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			regRdData <= 8'h00;
		end else if (regRd) begin
			case (regAddr)
				gcf_pkg::OFS_PEAK0_LO: regRdData <= peak0Lo;
				gcf_pkg::OFS_PEAK0_HI: regRdData <= {4'h0, peak0Hi};
				gcf_pkg::OFS_PEAK1_LO: regRdData <= peak1Lo;
				gcf_pkg::OFS_PEAK1_HI: regRdData <= {4'h0, peak1Hi};
				gcf_pkg::OFS_FLOOR_LO: regRdData <= floorLo;
				gcf_pkg::OFS_FLOOR_HI: regRdData <= {4'h0, floorHi};
				gcf_pkg::OFS_HOLD_MANT: regRdData <= holdMant;
				gcf_pkg::OFS_HOLD_EXP: regRdData <= {4'h0, holdExp};
				gcf_pkg::OFS_SRC0: regRdData <= {5'h00, firstFlagSource};
				gcf_pkg::OFS_SRC1: regRdData <= {5'h00, secondFlagSource};
				gcf_pkg::OFS_FLAG_EN: begin
					regRdData <= {3'h0, combineReset, 2'h0, secondFlagOutputOn,
						firstFlagOutputOn};
				end
				gcf_pkg::OFS_RST_LIMIT: regRdData <= {5'h00, resetCountLimit};
				gcf_pkg::OFS_RST_LEN: regRdData <= {3'h0, resetPulseLength};
				gcf_pkg::OFS_IRQ_STATUS: regRdData <= {4'h0, irqStatus};
				gcf_pkg::OFS_IRQ_MASK: regRdData <= {4'h0, irqMask};
				gcf_pkg::OFS_LIVE: regRdData <= {4'h0, ind};
				default: regRdData <= 8'h00; // Unmapped reads as zero
			endcase
		end else begin
			regRdData <= 8'h00;
		end
	end

	// Upper threshold compares, updated on each peak sample
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			ind.above0 <= 1'b0;
			ind.above1 <= 1'b0;
		end else if (peakValid) begin
			ind.above0 <= peakMag > thr0;
			ind.above1 <= peakMag > thr1;
		end
	end

	// Floor hold timer: restarts when the peak reaches the floor
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			holdCount <= 24'h00_0000;
			ind.below <= 1'b0;
		end else if (peakValid) begin
			if (peakMag >= thrFloor) begin
				holdCount <= 24'h00_0000;
				ind.below <= 1'b0;
			end else if (holdCount + 24'h00_0001 >= holdTarget) begin
				holdCount <= holdTarget; // Saturate once the interval is met
				ind.below <= 1'b1;
			end else begin
				holdCount <= holdCount + 24'h00_0001;
			end
		end
	end

	// Full-scale window and converter reset pulse, counted in converter clocks
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			fsWindow <= 8'h00;
			pulseCount <= 8'h00;
			ind.resetPulse <= 1'b0;
		end else if (convValid) begin
			fsWindow <= {fsWindow[6:0], convFullScale};
			if (pulseCount != 8'h00) begin
				pulseCount <= pulseCount - 8'h01;
				ind.resetPulse <= pulseCount != 8'h01;
			end else if (onesCount(fsWindow) > {1'b0, resetCountLimit}) begin
				pulseCount <= 8'(({3'h0, resetPulseLength} + 8'h01) * 8'(gcf_pkg::PULSE_UNIT));
				ind.resetPulse <= 1'b1;
				fsWindow <= 8'h00; // Fresh window after firing
			end
		end
	end

	// Sticky status: rising indicator sets, write-one clears, set wins
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			indPrev <= '0;
			irqStatus <= '0;
		end else begin
			indPrev <= ind;
			if (regWr && regAddr == gcf_pkg::OFS_IRQ_STATUS) begin
				irqStatus <= (irqStatus & ~regWrData[3:0]) | (ind & ~indPrev);
			end else begin
				irqStatus <= irqStatus | (ind & ~indPrev);
			end
		end
	end

	// Interrupt level and flag pins, registered
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			irq <= 1'b0;
			firstFlagPin <= 1'b0;
			secondFlagPin <= 1'b0;
		end else begin
			irq <= |(irqStatus & irqMask);
			firstFlagPin <= firstFlagOutputOn &
				pickFlag(firstFlagSource, ind, combineReset);
			secondFlagPin <= secondFlagOutputOn &
				pickFlag(secondFlagSource, ind, combineReset);
		end
	end
endmodule

// >>> rtl/gcf_pkg.sv
/*
 * Shared constants and types for the gain-control peak and flag output block:
 * register indices, field positions, reset values and flag source codes.
 * Assumes a plain register port with 8-bit data and byte-indexed offsets.
 */
package gcf_pkg;
	// Register offsets; printed offsets are not word aligned, so they are indices
	localparam logic [9:0] OFS_PEAK0_LO = 10'h193; // Upper threshold zero, low bits
	localparam logic [9:0] OFS_PEAK0_HI = 10'h194; // Upper threshold zero, high bits
	localparam logic [9:0] OFS_PEAK1_LO = 10'h195; // Upper threshold one, low bits
	localparam logic [9:0] OFS_PEAK1_HI = 10'h196; // Upper threshold one, high bits
	localparam logic [9:0] OFS_FLOOR_LO = 10'h197; // Floor threshold, low bits
	localparam logic [9:0] OFS_FLOOR_HI = 10'h198; // Floor threshold, high bits
	localparam logic [9:0] OFS_HOLD_MANT = 10'h199; // Hold interval mantissa
	localparam logic [9:0] OFS_HOLD_EXP = 10'h19a; // Hold interval exponent
	localparam logic [9:0] OFS_SRC0 = 10'h19b; // First flag source
	localparam logic [9:0] OFS_SRC1 = 10'h19c; // Second flag source
	localparam logic [9:0] OFS_FLAG_EN = 10'h19e; // Flag output enables
	localparam logic [9:0] OFS_RST_LIMIT = 10'h188; // Converter reset count limit
	localparam logic [9:0] OFS_RST_LEN = 10'h189; // Converter reset pulse length
	localparam logic [9:0] OFS_IRQ_STATUS = 10'h1a0; // Sticky event status
	localparam logic [9:0] OFS_IRQ_MASK = 10'h1a1; // Interrupt mask
	localparam logic [9:0] OFS_LIVE = 10'h1a2; // Live indicator state

	// Field positions in the enable register
	localparam int BIT_FLAG0_ON = 0; // First flag output on
	localparam int BIT_FLAG1_ON = 1; // Second flag output on
	localparam int BIT_COMBINE = 4; // OR the reset pulse into peak flags

	// Reset values
	localparam logic [7:0] RST_ZERO = 8'h00; // Most registers
	localparam logic [2:0] RST_LIMIT = 3'h5; // Count limit after reset
	localparam logic [4:0] RST_LEN = 5'h01; // Pulse length after reset

	// Converter samples per window and per pulse-length unit
	localparam int WINDOW_SAMPLES = 8; // Samples in the full-scale window
	localparam int PULSE_UNIT = 8; // Converter clocks per pulse unit

	// Flag source codes
	typedef enum logic [2:0] {
		SRC_RESET = 3'b000, // Converter reset pulse
		SRC_ABOVE0 = 3'b100, // Peak above threshold zero
		SRC_ABOVE1 = 3'b101, // Peak above threshold one
		SRC_BELOW = 3'b110 // Peak below floor for hold interval
	} gcf_src_e;

	// Indicator bundle, also the layout of status, mask and live registers
	typedef struct packed {
		logic below; // Bit 3: below floor for hold interval
		logic above1; // Bit 2: above threshold one
		logic above0; // Bit 1: above threshold zero
		logic resetPulse; // Bit 0: converter reset pulse
	} gcf_ind_s;
endpackage
